/* logic/pcir_map.vh */
// register offsets, field positions, reset values and counts of the clock/irq block
`ifndef PCIR_MAP_VH
`define PCIR_MAP_VH

// byte offsets on the avalon slave
`define PCIR_OFS_PCK0 6'h00
`define PCIR_OFS_PCK1 6'h04
`define PCIR_OFS_PCK2 6'h08
`define PCIR_OFS_IER 6'h0c
`define PCIR_OFS_IDR 6'h10
`define PCIR_OFS_SR 6'h14
`define PCIR_OFS_IMR 6'h18
`define PCIR_OFS_EVT 6'h1c
`define PCIR_OFS_OSC 6'h20
`define PCIR_OFS_PLL 6'h24

// programmable clock config fields
`define PCIR_CSS_LSB 0
`define PCIR_CSS_MSB 1
`define PCIR_PRESCALE_CODE_LSB 2
`define PCIR_PRESCALE_CODE_MSB 4
`define PCIR_CSS_SLOW 2'h0
`define PCIR_CSS_MAIN 2'h1
`define PCIR_CSS_RSVD 2'h2
`define PCIR_CSS_PLL 2'h3
`define PCIR_PRESCALE_CODE_RSVD 3'h7
`define PCIR_PCK_RESET 5'h00

// status / enable / disable / mask bit positions
`define PCIR_BIT_OSC 0
`define PCIR_BIT_LOCK 2
`define PCIR_BIT_MRDY 3
`define PCIR_BIT_PRDY0 8
`define PCIR_IRQ_W 11
`define PCIR_IRQ_VALID 11'h70d
`define PCIR_IMR_RESET 11'h70d

// oscillator register fields
`define PCIR_OSC_EN_BIT 0
`define PCIR_OSC_BYP_BIT 1
`define PCIR_OSC_CNT_LSB 8
`define PCIR_OSC_CNT_MSB 15
`define PCIR_OSC_MULT_SHIFT 3

// pll register fields
`define PCIR_PLL_CNT_LSB 8
`define PCIR_PLL_CNT_MSB 13

`endif

/* logic/pcir_pck_gen.v */
// one programmable clock output: source pick, power-of-two prescale, ready flag
`timescale 1ns/1ps
`default_nettype none
`include "pcir_map.vh"

module pcir_pck_gen (
  input wire clk,
  input wire srst,
  input wire restart,
  input wire [1:0] css,
  input wire [2:0] prescale_code,
  input wire slow_tick,
  input wire main_tick,
  input wire pll_tick,
  output reg pck_pulse,
  output reg pck_ready
);

  reg [5:0] cnt_q;
  reg src_tick;
  wire setting_ok;
  wire [5:0] last_cnt;

  // reserved source or prescale codes stop the output altogether
  assign setting_ok = (css != `PCIR_CSS_RSVD) && (prescale_code != `PCIR_PRESCALE_CODE_RSVD);
  assign last_cnt = (6'h01 << prescale_code) - 6'h01;

  always @* begin
    case (css)
      `PCIR_CSS_SLOW: src_tick = slow_tick;
      `PCIR_CSS_MAIN: src_tick = main_tick;
      `PCIR_CSS_PLL: src_tick = pll_tick;
      default: src_tick = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (srst || restart) begin
      cnt_q <= 6'h00;
      pck_pulse <= 1'b0;
      pck_ready <= 1'b0;
    end else begin
      pck_pulse <= 1'b0;
      if (setting_ok && src_tick) begin
        if (cnt_q == last_cnt) begin
          cnt_q <= 6'h00;
          pck_pulse <= 1'b1;
          // ready only after a full period at the new setting
          pck_ready <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

endmodule // pcir_pck_gen
`default_nettype wire

/* logic/pcir_top.v */
// clock-event status, interrupt enable/mask and programmable clock registers
// How it works
// - source field 00 slow, 01 main, 11 pll
// - prescale code divides source by two-power
// - enable write of one enables source
// - disable write of one disables source
// - status bit 0 shows oscillator stable
// - status bit 2 shows pll locked
// - status bit 3 shows master clock ready
// - status bits 8-10 show outputs ready
// - mask reads zero enabled, one disabled
// - oscillator stable after programmed start-up time
// - lock set after programmed slow cycles
`timescale 1ns/1ps
`default_nettype none
`include "pcir_map.vh"

module pcir_top (
  input wire clk,
  input wire srst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire slow_tick,
  input wire main_tick,
  input wire pll_tick,
  input wire master_ready_in,
  output reg irq,
  output wire [2:0] prog_clk_pulse,
  output wire [2:0] prog_output_ready_flag
);

  // configuration and state
  reg [4:0] pck_cfg_q [0:2];
  reg [`PCIR_IRQ_W-1:0] imr_q;
  reg [`PCIR_IRQ_W-1:0] evt_q;
  reg [`PCIR_IRQ_W-1:0] prev_q;
  reg osc_en_q;
  reg osc_byp_q;
  reg [7:0] osc_cnt_q;
  reg [10:0] osc_timer_q;
  reg oscillator_stable_flag;
  reg [5:0] pll_cnt_q;
  reg [5:0] pll_timer_q;
  reg pll_busy_q;
  reg lock_q;
  reg master_ready_flag;
  reg [`PCIR_IRQ_W-1:0] status;
  reg [`PCIR_IRQ_W-1:0] evt_d;
  reg [31:0] rd_mux;
  wire [`PCIR_IRQ_W-1:0] wbits;
  wire [2:0] pck_restart;
  wire wr_fire;
  wire [10:0] osc_target;
  integer i;

  // write is taken only at the edge where waitrequest is seen low
  assign wr_fire = avs_write && !avs_waitrequest;
  assign wbits = avs_writedata[`PCIR_IRQ_W-1:0] & `PCIR_IRQ_VALID;
  assign osc_target = {osc_cnt_q, 3'h0};

  function hit;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign pck_restart[0] = wr_fire && hit(avs_address, `PCIR_OFS_PCK0);
  assign pck_restart[1] = wr_fire && hit(avs_address, `PCIR_OFS_PCK1);
  assign pck_restart[2] = wr_fire && hit(avs_address, `PCIR_OFS_PCK2);

  // avalon slave: one wait cycle per access, read data captured beforehand
  always @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= rd_mux;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // live status vector
  always @* begin
    status = {`PCIR_IRQ_W{1'b0}};
    status[`PCIR_BIT_OSC] = oscillator_stable_flag;
    status[`PCIR_BIT_LOCK] = lock_q;
    status[`PCIR_BIT_MRDY] = master_ready_flag;
    status[`PCIR_BIT_PRDY0 +: 3] = prog_output_ready_flag;
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `PCIR_OFS_PCK0: rd_mux[4:0] = pck_cfg_q[0];
      `PCIR_OFS_PCK1: rd_mux[4:0] = pck_cfg_q[1];
      `PCIR_OFS_PCK2: rd_mux[4:0] = pck_cfg_q[2];
      `PCIR_OFS_SR: rd_mux[`PCIR_IRQ_W-1:0] = status;
      `PCIR_OFS_IMR: rd_mux[`PCIR_IRQ_W-1:0] = imr_q;
      `PCIR_OFS_EVT: rd_mux[`PCIR_IRQ_W-1:0] = evt_q;
      `PCIR_OFS_OSC: begin
        rd_mux[`PCIR_OSC_EN_BIT] = osc_en_q;
        rd_mux[`PCIR_OSC_BYP_BIT] = osc_byp_q;
        rd_mux[`PCIR_OSC_CNT_MSB:`PCIR_OSC_CNT_LSB] = osc_cnt_q;
      end
      `PCIR_OFS_PLL: rd_mux[`PCIR_PLL_CNT_MSB:`PCIR_PLL_CNT_LSB] = pll_cnt_q;
      // write-only enable/disable and unmapped offsets read zero
      default: rd_mux = 32'h00000000;
    endcase
  end

  // programmable clock configuration
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < 3; i = i + 1) begin
        pck_cfg_q[i] <= `PCIR_PCK_RESET;
      end
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (pck_restart[i]) begin
          pck_cfg_q[i] <= avs_writedata[`PCIR_PRESCALE_CODE_MSB:`PCIR_CSS_LSB];
        end
      end
    end
  end

  // mask: a set bit means the source is disabled
  always @(posedge clk) begin
    if (srst) begin
      imr_q <= `PCIR_IMR_RESET;
    end else if (wr_fire && hit(avs_address, `PCIR_OFS_IER)) begin
      imr_q <= imr_q & ~wbits;
    end else if (wr_fire && hit(avs_address, `PCIR_OFS_IDR)) begin
      imr_q <= imr_q | wbits;
    end
  end

  // sticky events on each rising status flag; a new rise beats a clear
  always @* begin
    evt_d = evt_q;
    if (wr_fire && hit(avs_address, `PCIR_OFS_EVT)) begin
      evt_d = evt_d & ~wbits;
    end
    evt_d = evt_d | (status & ~prev_q);
  end

  always @(posedge clk) begin
    if (srst) begin
      evt_q <= {`PCIR_IRQ_W{1'b0}};
      prev_q <= {`PCIR_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      evt_q <= evt_d;
      prev_q <= status;
      irq <= |(evt_d & ~imr_q);
    end
  end

  // main oscillator: start-up time is counted in slow ticks times eight
  always @(posedge clk) begin
    if (srst) begin
      osc_en_q <= 1'b0;
      osc_byp_q <= 1'b0;
      osc_cnt_q <= 8'h00;
      osc_timer_q <= 11'h000;
      oscillator_stable_flag <= 1'b0;
    end else if (wr_fire && hit(avs_address, `PCIR_OFS_OSC)) begin
      osc_en_q <= avs_writedata[`PCIR_OSC_EN_BIT];
      osc_byp_q <= avs_writedata[`PCIR_OSC_BYP_BIT];
      osc_cnt_q <= avs_writedata[`PCIR_OSC_CNT_MSB:`PCIR_OSC_CNT_LSB];
      if (!avs_writedata[`PCIR_OSC_EN_BIT] && !avs_writedata[`PCIR_OSC_BYP_BIT]) begin
        oscillator_stable_flag <= 1'b0;
        osc_timer_q <= 11'h000;
      end
    end else if (osc_byp_q) begin
      oscillator_stable_flag <= 1'b1;
    end else if (osc_en_q && !oscillator_stable_flag) begin
      if (osc_timer_q >= osc_target) begin
        oscillator_stable_flag <= 1'b1;
      end else if (slow_tick) begin
        osc_timer_q <= osc_timer_q + 11'h001;
      end
    end
  end

  // pll lock: every write restarts the lock count in slow ticks
  always @(posedge clk) begin
    if (srst) begin
      pll_cnt_q <= 6'h00;
      pll_timer_q <= 6'h00;
      pll_busy_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (wr_fire && hit(avs_address, `PCIR_OFS_PLL)) begin
      pll_cnt_q <= avs_writedata[`PCIR_PLL_CNT_MSB:`PCIR_PLL_CNT_LSB];
      pll_timer_q <= 6'h00;
      pll_busy_q <= 1'b1;
      lock_q <= 1'b0;
    end else if (pll_busy_q) begin
      if (pll_timer_q == pll_cnt_q) begin
        pll_busy_q <= 1'b0;
        lock_q <= 1'b1;
      end else if (slow_tick) begin
        pll_timer_q <= pll_timer_q + 6'h01;
      end
    end
  end

  // master ready comes from the master clock switch logic outside
  always @(posedge clk) begin
    if (srst) begin
      master_ready_flag <= 1'b0;
    end else begin
      master_ready_flag <= master_ready_in;
    end
  end

  pcir_pck_gen u_pck0 (
    .clk(clk),
    .srst(srst),
    .restart(pck_restart[0]),
    .css(pck_cfg_q[0][`PCIR_CSS_MSB:`PCIR_CSS_LSB]),
    .prescale_code(pck_cfg_q[0][`PCIR_PRESCALE_CODE_MSB:`PCIR_PRESCALE_CODE_LSB]),
    .slow_tick(slow_tick),
    .main_tick(main_tick),
    .pll_tick(pll_tick),
    .pck_pulse(prog_clk_pulse[0]),
    .pck_ready(prog_output_ready_flag[0])
  );

  pcir_pck_gen u_pck1 (
    .clk(clk),
    .srst(srst),
    .restart(pck_restart[1]),
    .css(pck_cfg_q[1][`PCIR_CSS_MSB:`PCIR_CSS_LSB]),
    .prescale_code(pck_cfg_q[1][`PCIR_PRESCALE_CODE_MSB:`PCIR_PRESCALE_CODE_LSB]),
    .slow_tick(slow_tick),
    .main_tick(main_tick),
    .pll_tick(pll_tick),
    .pck_pulse(prog_clk_pulse[1]),
    .pck_ready(prog_output_ready_flag[1])
  );

  pcir_pck_gen u_pck2 (
    .clk(clk),
    .srst(srst),
    .restart(pck_restart[2]),
    .css(pck_cfg_q[2][`PCIR_CSS_MSB:`PCIR_CSS_LSB]),
    .prescale_code(pck_cfg_q[2][`PCIR_PRESCALE_CODE_MSB:`PCIR_PRESCALE_CODE_LSB]),
    .slow_tick(slow_tick),
    .main_tick(main_tick),
    .pll_tick(pll_tick),
    .pck_pulse(prog_clk_pulse[2]),
    .pck_ready(prog_output_ready_flag[2])
  );

endmodule // pcir_top
`default_nettype wire

/* test/pcir_sva.sv */
// assertion checker for the clock and interrupt register block
`timescale 1ns/1ps
`default_nettype none
`include "pcir_map.vh"
module pcir_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic slow_tick,
  input wire logic main_tick,
  input wire logic pll_tick,
  input wire logic master_ready_in,
  input wire logic irq,
  input wire logic [2:0] prog_clk_pulse,
  input wire logic [2:0] prog_output_ready_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  chk_ier_reads_zero: assert property (avs_read && !avs_waitrequest && avs_address == `PCIR_OFS_IER |-> avs_readdata == 32'h0)
    else $error("enable reg readable");
  chk_imr_layout: assert property (avs_read && !avs_waitrequest && avs_address == `PCIR_OFS_IMR |-> (avs_readdata & ~32'h70d) == 32'h0)
    else $error("mask bits out of layout");
  chk_idr_quiets_irq: assert property (avs_write && !avs_waitrequest && avs_address == `PCIR_OFS_IDR && avs_writedata[10:0] == 11'h70d |-> ##2 !irq)
    else $error("irq after full disable");
  chk_irq_reset_low: assert property (disable iff (1'b0) srst |=> !irq)
    else $error("irq during reset");
  chk_ready_rewrite: assert property (avs_write && !avs_waitrequest && avs_address == `PCIR_OFS_PCK0 |=> !prog_output_ready_flag[0])
    else $error("ready kept over rewrite");
  chk_ready_on_pulse: assert property ($rose(prog_output_ready_flag[0]) |-> prog_clk_pulse[0])
    else $error("ready without pulse");
  chk_pulse_after_tick: assert property (prog_clk_pulse != 3'h0 |-> $past(slow_tick || main_tick || pll_tick))
    else $error("pulse without tick");
  cov_irq: cover property ($rose(irq));
  cov_pulse2: cover property (prog_clk_pulse[2]);
  cov_ready: cover property ($rose(prog_output_ready_flag[1]));
endmodule // pcir_sva
bind pcir_top pcir_sva u_sva (.*);
`default_nettype wire

/* test/pcir_top_tb_top.sv */
// self-checking bench for the clock and interrupt register block
`timescale 1ns/1ps
`default_nettype none
`include "pcir_map.vh"
module pcir_top_tb_top;
  logic clk = 0, srst = 1, rd = 0, wr = 0, mrdy = 0, st = 0, mt = 0, pt = 0;
  logic [5:0] addr = 6'h0;
  logic [31:0] wd = 32'h0, rdata, rv;
  logic wreq, irq;
  logic [2:0] pulse, rdy;
  int fail_count = 0, n_checks = 0, cnt = 0, g;
  int css[3] = '{0, 1, 3};
  int per[3] = '{16, 4, 6};
  always #10 clk = ~clk;
  // free-running ticks: slow every 8, main every 2, pll every 3 cycles
  always @(posedge clk) begin
    cnt <= cnt + 1;
    st <= cnt % 8 == 7;
    mt <= cnt % 2 == 1;
    pt <= cnt % 3 == 2;
  end
  pcir_top DUT (.clk(clk), .srst(srst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq), .slow_tick(st),
    .main_tick(mt), .pll_tick(pt), .master_ready_in(mrdy), .irq(irq),
    .prog_clk_pulse(pulse), .prog_output_ready_flag(rdy));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // sampling right at the edge sees the pre-edge registered values
  task automatic acc(logic w, logic [5:0] a, logic [31:0] d);
    int i;
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    rv = rdata;
    if (i == 20) begin
      fail_count++;
      results();
    end
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic sr_bit(int b, logic e);
    acc(0, `PCIR_OFS_SR, 0);
    check("sr bit", rv[b], e);
  endtask
  // g ends as the cycle distance between two pulses, 300 if none
  task automatic gap(int b);
    for (g = 0; g < 300 && pulse[b] !== 1'b1; g++) @(posedge clk);
    @(posedge clk);
    for (g = 1; g < 300 && pulse[b] !== 1'b1; g++) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 0;
    repeat (20) @(posedge clk);
    acc(0, `PCIR_OFS_SR, 0);
    check("sr reset", rv, 32'h700);
    acc(0, `PCIR_OFS_IMR, 0);
    check("imr reset", rv, 32'h70d);
    acc(0, 6'h3c, 0);
    check("unmapped", rv, 32'h0);
    acc(0, `PCIR_OFS_IER, 0);
    check("ier read", rv, 32'h0);
    $display("done: reset values");
    acc(1, `PCIR_OFS_IMR, 0);
    acc(1, `PCIR_OFS_IER, 0);
    acc(0, `PCIR_OFS_IMR, 0);
    check("imr kept", rv, 32'h70d);
    mrdy <= 1;
    repeat (4) @(posedge clk);
    check("irq masked", irq, 1'b0);
    sr_bit(3, 1);
    acc(1, `PCIR_OFS_IER, 32'h8);
    acc(0, `PCIR_OFS_IMR, 0);
    check("imr enabled", rv, 32'h705);
    repeat (2) @(posedge clk);
    check("irq on", irq, 1'b1);
    acc(1, `PCIR_OFS_IDR, 32'h70d);
    acc(0, `PCIR_OFS_IMR, 0);
    check("imr disabled", rv, 32'h70d);
    check("irq off", irq, 1'b0);
    acc(0, `PCIR_OFS_EVT, 0);
    check("evt sticky", rv, 32'h708);
    acc(1, `PCIR_OFS_IER, 32'h8);
    repeat (2) @(posedge clk);
    check("irq again", irq, 1'b1);
    acc(1, `PCIR_OFS_EVT, 32'h8);
    check("irq cleared", irq, 1'b0);
    acc(0, `PCIR_OFS_EVT, 0);
    check("evt cleared", rv, 32'h700);
    mrdy <= 0;
    repeat (2) @(posedge clk);
    sr_bit(3, 0);
    $display("done: interrupts");
    for (int p = 0; p < 7; p++) begin
      acc(1, `PCIR_OFS_PCK1, p << 2 | 1);
      gap(1);
      check("prescale_code gap", g, 2 << p);
    end
    sr_bit(9, 1);
    foreach (css[k]) begin
      acc(1, `PCIR_OFS_PCK2, 32'h4 | css[k]);
      gap(2);
      check("css gap", g, per[k]);
    end
    acc(1, `PCIR_OFS_PCK0, 32'h2);
    repeat (100) @(posedge clk);
    sr_bit(8, 0);
    acc(1, `PCIR_OFS_PCK2, 32'h1c);
    repeat (100) @(posedge clk);
    sr_bit(10, 0);
    $display("done: prog clocks");
    acc(1, `PCIR_OFS_OSC, 32'h101);
    repeat (30) @(posedge clk);
    sr_bit(0, 0);
    repeat (60) @(posedge clk);
    sr_bit(0, 1);
    acc(1, `PCIR_OFS_PLL, 32'h100);
    repeat (30) @(posedge clk);
    sr_bit(2, 1);
    acc(1, `PCIR_OFS_PLL, 32'h400);
    sr_bit(2, 0);
    repeat (50) @(posedge clk);
    sr_bit(2, 1);
    acc(1, `PCIR_OFS_OSC, 32'h0);
    sr_bit(0, 0);
    acc(1, `PCIR_OFS_OSC, 32'h2);
    sr_bit(0, 1);
    $display("done: osc and pll");
    results();
  end
endmodule // pcir_top_tb_top
`default_nettype wire
